// ### core/pmt_pkg.sv
// package: register map, field layout, reset values and types for the period-match timer
// Summary of operation
// R01 - prescale 00:1, 01:4, 1x:16 per increment
// R02 - postscale code n gives interrupt per n+1 matches
// R03 - timer counts only while timer_on is set
// R04 - count rises to period then wraps zero
// R05 - period register resets to all ones
// R06 - period register read and write anytime
// R07 - count readable, writable, zero on reset
// R08 - count or control write clears both scalers
// R09 - control write leaves count unchanged
// R10 - postscaler completion sets latched interrupt flag
// R11 - reset leaves timer_on at zero
// R12 - raw match output feeds serial port
// R13 - count and match feed pwm time base
// R14 - control bit 7 reads zero, ignores writes
// R15 - flag stays set until software clears
package pmt_pkg;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_COUNT   = 3'h1;
  localparam logic [2:0] ADDR_PERIOD  = 3'h2;
  localparam logic [2:0] ADDR_STATUS  = 3'h3;
  localparam logic [2:0] ADDR_MASK    = 3'h4;

  localparam int CTL_PRESCALE_LSB  = 0;
  localparam int CTL_ON_BIT        = 2;
  localparam int CTL_POSTSCALE_LSB = 3;

  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST  = 8'hFF;
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [7:0] CONTROL_WMASK = 8'h7F;

  localparam logic [3:0] PRE_DIV4_LAST  = 4'h3;
  localparam logic [3:0] PRE_DIV16_LAST = 4'hF;
  localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

  typedef struct packed {
    logic       unused7;
    logic [3:0] postscale_select;
    logic       timer_on;
    logic [1:0] prescale_select;
  } pmt_control_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmt_bus_t;
endpackage : pmt_pkg

// ### core/pmt_timer.sv
// period-match timer: prescaler, 8-bit count, period compare, postscaler, irq
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer
  import pmt_pkg::*;
(
  input  wire  logic       ref_clk,
  input  wire  logic       nrst,
  input  wire  logic [2:0] bus_addr,
  input  wire  logic [7:0] bus_wdata,
  input  wire  logic       bus_wr,
  input  wire  logic       bus_rd,
  output logic       [7:0] bus_rdata,
  output logic             irq,
  output logic             ssp_clk_src,
  output logic             pwm_match,
  output logic       [7:0] pwm_count
);
  pmt_bus_t     bus;
  pmt_control_t ctl_r;
  logic [7:0] count_r, period_r, mask_r;
  logic [1:0] instr_r;
  logic [3:0] pre_r, post_r;
  logic       flag_r;

  assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

  function automatic logic hit(input pmt_bus_t b, input logic [2:0] a);
    return b.addr == a;
  endfunction : hit

  wire wr_ctl    = bus.wr && hit(bus, ADDR_CONTROL);
  wire wr_cnt    = bus.wr && hit(bus, ADDR_COUNT);
  wire wr_per    = bus.wr && hit(bus, ADDR_PERIOD);
  wire wr_mask   = bus.wr && hit(bus, ADDR_MASK);
  wire rd_status = bus.rd && hit(bus, ADDR_STATUS);
  wire scl_clr   = wr_ctl || wr_cnt; // R08

  // instruction clock is ref_clk / 4
  wire instr_tick = instr_r == INSTR_DIV_LAST;
  wire [3:0] pre_last = ctl_r.prescale_select[1] ? PRE_DIV16_LAST :
                        ctl_r.prescale_select[0] ? PRE_DIV4_LAST : 4'h0; // R01
  wire inc_tick = ctl_r.timer_on && instr_tick && (pre_r == pre_last) && !scl_clr; // R03
  wire match    = count_r == period_r; // R04
  wire wrap     = inc_tick && match; // R04
  wire post_done = wrap && (post_r == ctl_r.postscale_select); // R02 R10
  wire [7:0] status_v = {7'h00, flag_r};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) instr_r <= 2'h0;
    else       instr_r <= instr_r + 2'h1;
  end

  // scalers restart on count and control writes so the next period is whole
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pre_r  <= 4'h0;
      post_r <= 4'h0;
    end else if (scl_clr) begin
      pre_r  <= 4'h0; // R08
      post_r <= 4'h0; // R08
    end else begin
      if (ctl_r.timer_on && instr_tick)
        pre_r <= (pre_r == pre_last) ? 4'h0 : pre_r + 4'h1; // R01
      if (wrap)
        post_r <= post_done ? 4'h0 : post_r + 4'h1; // R02
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)       count_r <= COUNT_RST; // R07
    else if (wr_cnt) count_r <= bus.wdata; // R07
    else if (inc_tick) count_r <= match ? 8'h00 : count_r + 8'h01; // R04 R09
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_r    <= CONTROL_RST; // R11
      period_r <= PERIOD_RST; // R05
      mask_r   <= MASK_RST;
    end else begin
      if (wr_ctl)  ctl_r    <= bus.wdata & CONTROL_WMASK; // R14
      if (wr_per)  period_r <= bus.wdata; // R06
      if (wr_mask) mask_r   <= {7'h00, bus.wdata[0]};
    end
  end

  // set beats the read-clear so a postscaler completion in the read cycle is kept
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)          flag_r <= 1'b0;
    else if (post_done) flag_r <= 1'b1; // R10 R15
    else if (rd_status) flag_r <= 1'b0; // R15
  end

  // one decode for the read path; unmapped offsets read as zero
  function automatic logic [7:0] read_sel(input logic [2:0] a, input pmt_control_t c,
                                          input logic [7:0] cnt, input logic [7:0] per,
                                          input logic [7:0] st, input logic [7:0] msk);
    case (a)
      ADDR_CONTROL: return c & CONTROL_WMASK; // R14
      ADDR_COUNT:   return cnt;
      ADDR_PERIOD:  return per; // R06
      ADDR_STATUS:  return st;
      ADDR_MASK:    return msk;
      default:      return 8'h00;
    endcase
  endfunction : read_sel

  wire [7:0] rd_mux = read_sel(bus.addr, ctl_r, count_r, period_r, status_v, mask_r);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_rdata   <= 8'h00;
      irq         <= 1'b0;
      ssp_clk_src <= 1'b0;
      pwm_match   <= 1'b0;
      pwm_count   <= 8'h00;
    end else begin
      bus_rdata   <= bus.rd ? rd_mux : 8'h00;
      irq         <= (post_done || (flag_r && !rd_status)) && mask_r[0];
      ssp_clk_src <= wrap; // R12
      pwm_match   <= wrap; // R13
      pwm_count   <= count_r; // R13
    end
  end

  // count and wrap checks
  chk_wrap_zero: assert property ( // R04
    @(posedge ref_clk) disable iff (!nrst)
    wrap && !wr_cnt
    |=> count_r == 8'h00
  ) else $error("count did not wrap");

  chk_ctl_keeps_count: assert property ( // R09
    @(posedge ref_clk) disable iff (!nrst)
    wr_ctl && !inc_tick
    |=> $stable(count_r)
  ) else $error("control write moved count");

  chk_off_holds: assert property ( // R03
    @(posedge ref_clk) disable iff (!nrst)
    !ctl_r.timer_on && !wr_cnt
    |=> $stable(count_r)
  ) else $error("count moved while off");

  chk_inc_step: assert property ( // R04
    @(posedge ref_clk) disable iff (!nrst)
    inc_tick && !match
    |=> count_r == $past(count_r) + 8'h01
  ) else $error("count did not step by one");

  chk_count_idle: assert property ( // R04
    @(posedge ref_clk) disable iff (!nrst)
    !inc_tick && !wr_cnt
    |=> $stable(count_r)
  ) else $error("count moved without a tick");

  chk_count_write: assert property ( // R07
    @(posedge ref_clk) disable iff (!nrst)
    wr_cnt
    |=> count_r == $past(bus_wdata)
  ) else $error("count not written");

  // scaler checks; a stale scaler would stretch the first period after a write
  chk_scaler_clear: assert property ( // R08
    @(posedge ref_clk) disable iff (!nrst)
    scl_clr
    |=> pre_r == 4'h0 && post_r == 4'h0
  ) else $error("scalers not cleared");

  chk_scl_no_inc: assert property ( // R08
    @(posedge ref_clk) disable iff (!nrst)
    scl_clr
    |-> !inc_tick
  ) else $error("count moved in a write cycle");

  chk_pre_one: assert property ( // R01
    @(posedge ref_clk) disable iff (!nrst)
    ctl_r.prescale_select == 2'b00 && ctl_r.timer_on && instr_tick && !scl_clr
    |-> inc_tick
  ) else $error("1:1 prescale missed");

  chk_pre_four: assert property ( // R01
    @(posedge ref_clk) disable iff (!nrst)
    ctl_r.prescale_select == 2'b01 && pre_r != PRE_DIV4_LAST
    |-> !inc_tick
  ) else $error("1:4 prescale fired early");

  chk_pre_sixteen: assert property ( // R01
    @(posedge ref_clk) disable iff (!nrst)
    ctl_r.prescale_select[1] && pre_r != PRE_DIV16_LAST
    |-> !inc_tick
  ) else $error("1:16 prescale fired early");

  // holds because a prescale change always comes with a scaler clear
  chk_pre_range: assert property ( // R01
    @(posedge ref_clk) disable iff (!nrst)
    pre_r <= pre_last
  ) else $error("prescaler past its limit");

  chk_pre_idle: assert property ( // R03
    @(posedge ref_clk) disable iff (!nrst)
    !ctl_r.timer_on && !scl_clr
    |=> $stable(pre_r)
  ) else $error("prescaler ran while off");

  chk_instr_wrap: assert property ( // R01
    @(posedge ref_clk) disable iff (!nrst)
    instr_tick
    |=> instr_r == 2'h0
  ) else $error("instruction divider did not wrap");

  chk_instr_step: assert property ( // R01
    @(posedge ref_clk) disable iff (!nrst)
    !instr_tick
    |=> instr_r == $past(instr_r) + 2'h1
  ) else $error("instruction divider stalled");

  chk_post_range: assert property ( // R02
    @(posedge ref_clk) disable iff (!nrst)
    post_r <= ctl_r.postscale_select
  ) else $error("postscaler past its limit");

  chk_post_step: assert property ( // R02
    @(posedge ref_clk) disable iff (!nrst)
    wrap && !post_done
    |=> post_r == $past(post_r) + 4'h1
  ) else $error("postscaler missed a match");

  chk_post_idle: assert property ( // R02
    @(posedge ref_clk) disable iff (!nrst)
    !wrap && !scl_clr
    |=> $stable(post_r)
  ) else $error("postscaler moved without a match");

  chk_post_match: assert property ( // R10
    @(posedge ref_clk) disable iff (!nrst)
    post_done
    |-> match && inc_tick
  ) else $error("postscaler done without a match");

  // flag and interrupt checks
  chk_flag_sticky: assert property ( // R15
    @(posedge ref_clk) disable iff (!nrst)
    flag_r && !rd_status
    |=> flag_r
  ) else $error("flag dropped");

  chk_flag_set: assert property ( // R10
    @(posedge ref_clk) disable iff (!nrst)
    post_done
    |=> flag_r
  ) else $error("flag not set");

  chk_flag_clear: assert property ( // R15
    @(posedge ref_clk) disable iff (!nrst)
    rd_status && !post_done
    |=> !flag_r
  ) else $error("status read did not clear flag");

  chk_flag_quiet: assert property ( // R10
    @(posedge ref_clk) disable iff (!nrst)
    !flag_r && !post_done
    |=> !flag_r
  ) else $error("flag set without postscaler");

  chk_irq_high: assert property ( // R10
    @(posedge ref_clk) disable iff (!nrst)
    flag_r && mask_r[0] && !rd_status
    |=> irq
  ) else $error("irq missing while flag set");

  chk_irq_masked: assert property ( // R10
    @(posedge ref_clk) disable iff (!nrst)
    !mask_r[0]
    |=> !irq
  ) else $error("irq while masked");

  chk_irq_clear: assert property ( // R15
    @(posedge ref_clk) disable iff (!nrst)
    !flag_r && !post_done
    |=> !irq
  ) else $error("irq without flag");

  // outputs to the serial port and pwm unit
  chk_ssp_src: assert property ( // R12
    @(posedge ref_clk) disable iff (!nrst)
    wrap
    |=> ssp_clk_src
  ) else $error("match not forwarded");

  chk_match_pulse: assert property ( // R12
    @(posedge ref_clk) disable iff (!nrst)
    !wrap
    |=> !ssp_clk_src
  ) else $error("match pulse without wrap");

  chk_pwm_same: assert property ( // R13
    @(posedge ref_clk) disable iff (!nrst)
    pwm_match == ssp_clk_src
  ) else $error("pwm match differs from serial source");

  chk_pwm_count: assert property ( // R13
    @(posedge ref_clk) disable iff (!nrst)
    1'b1
    |=> pwm_count == $past(count_r)
  ) else $error("pwm count not tracking");

  // register bus checks
  chk_ctl_bit7: assert property ( // R14
    @(posedge ref_clk) disable iff (!nrst)
    bus.rd && hit(bus, ADDR_CONTROL)
    |=> !bus_rdata[7]
  ) else $error("bit 7 read high");

  chk_bit7_clear: assert property ( // R14
    @(posedge ref_clk) disable iff (!nrst)
    !ctl_r.unused7
  ) else $error("unused control bit stored");

  chk_ctl_write: assert property ( // R14
    @(posedge ref_clk) disable iff (!nrst)
    wr_ctl
    |=> ctl_r == ($past(bus_wdata) & CONTROL_WMASK)
  ) else $error("control not written");

  chk_period_write: assert property ( // R06
    @(posedge ref_clk) disable iff (!nrst)
    wr_per
    |=> period_r == $past(bus.wdata)
  ) else $error("period not written");

  chk_period_hold: assert property ( // R06
    @(posedge ref_clk) disable iff (!nrst)
    !wr_per
    |=> $stable(period_r)
  ) else $error("period moved without a write");

  chk_rd_count: assert property ( // R07
    @(posedge ref_clk) disable iff (!nrst)
    bus.rd && hit(bus, ADDR_COUNT)
    |=> bus_rdata == $past(count_r)
  ) else $error("count read wrong");

  chk_rd_period: assert property ( // R06
    @(posedge ref_clk) disable iff (!nrst)
    bus.rd && hit(bus, ADDR_PERIOD)
    |=> bus_rdata == $past(period_r)
  ) else $error("period read wrong");

  chk_rd_status: assert property ( // R15
    @(posedge ref_clk) disable iff (!nrst)
    rd_status
    |=> bus_rdata == {7'h00, $past(flag_r)}
  ) else $error("status read wrong");

  // read data stands only in the cycle after a read
  chk_rd_idle: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !bus.rd
    |=> bus_rdata == 8'h00
  ) else $error("read data outside a read");

  chk_mask_upper: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    mask_r[7:1] == 7'h00
  ) else $error("unused mask bits stored");

  cov_wrap:  cover property (@(posedge ref_clk) disable iff (!nrst) wrap);
  cov_post:  cover property (@(posedge ref_clk) disable iff (!nrst) post_done);
  cov_irq:   cover property (@(posedge ref_clk) disable iff (!nrst) irq);
  cov_race:  cover property (@(posedge ref_clk) disable iff (!nrst) post_done && rd_status);
  cov_pre16: cover property (@(posedge ref_clk) disable iff (!nrst) inc_tick && ctl_r.prescale_select[1]);
endmodule : pmt_timer
`default_nettype wire

// ### verification/tb_period_match_timer8.sv
// testbench: registers, wrap, scalers and interrupt of the period-match timer
`timescale 1ns/1ps
`default_nettype none
module tb_period_match_timer8;
  import pmt_pkg::*;
  logic       ref_clk   = 1'b0;
  logic       nrst      = 1'b0;
  logic [2:0] bus_addr  = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic       bus_wr    = 1'b0;
  logic       bus_rd    = 1'b0;
  logic [7:0] bus_rdata;
  logic       irq;
  logic       ssp_clk_src;
  logic       pwm_match;
  logic [7:0] pwm_count;
  int         err_count   = 0;
  int         checks_done = 0;
  logic [7:0] d;
  int         n;
  always #25 ref_clk = ~ref_clk;
  pmt_timer dut (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq),
    .ssp_clk_src(ssp_clk_src), .pwm_match(pwm_match), .pwm_count(pwm_count));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk) begin bus_addr <= a; bus_wdata <= v; bus_wr <= 1'b1; end
    @(posedge ref_clk) bus_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk) begin bus_addr <= a; bus_rd <= 1'b1; end
    @(posedge ref_clk) bus_rd <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask : rd
  // cycles between two match pulses; bounded so a dead timer cannot hang
  task automatic gap(output int c);
    int i;
    i = 0;
    do @(posedge ref_clk) #1; while (pwm_match !== 1'b1 && ++i < 4000);
    c = 0;
    do begin @(posedge ref_clk) #1; c++; end while (pwm_match !== 1'b1 && c < 4000);
    chk({7'h00, ssp_clk_src}, 8'h01);
  endtask : gap
  task automatic t_reset;
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT, 8'h00);
    rd(ADDR_PERIOD, 8'hFF);
    rd(ADDR_MASK, 8'h00);
    rd(3'h5, 8'h00);
    wr(ADDR_CONTROL, 8'hF8);
    rd(ADDR_CONTROL, 8'h78);
    $display("test reset done");
  endtask : t_reset
  task automatic t_wrap;
    wr(ADDR_PERIOD, 8'h02);
    rd(ADDR_PERIOD, 8'h02);
    wr(ADDR_CONTROL, 8'h04);
    gap(n);
    chk(8'(n), 8'd12);
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_PERIOD, 8'h01);
      wr(ADDR_CONTROL, {6'h01, 2'(p)});
      gap(n);
      chk(8'(n), 8'd8 << (2 * (p > 1 ? 2 : p)));
    end
    $display("test wrap done");
  endtask : t_wrap
  task automatic t_post;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_MASK, 8'h01);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h14);
    n = 0;
    for (int i = 0; i < 200 && irq !== 1'b1; i++) begin
      @(posedge ref_clk) #1;
      if (pwm_match === 1'b1) n++;
    end
    chk(8'(n), 8'd3);
    repeat (30) @(posedge ref_clk);
    #1 chk({7'h00, irq}, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_STATUS, 8'h01);
    @(posedge ref_clk) #1 chk({7'h00, irq}, 8'h00);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_CONTROL, 8'h14);
    repeat (60) @(posedge ref_clk);
    #1 chk({7'h00, irq}, 8'h00);
    rd(ADDR_STATUS, 8'h01);
    $display("test postscale done");
  endtask : t_post
  task automatic t_hold;
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT, 8'hA5);
    rd(ADDR_COUNT, 8'hA5);
    repeat (80) @(posedge ref_clk);
    #1 chk(pwm_count, 8'hA5);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT, 8'hA5);
    $display("test hold done");
  endtask : t_hold
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_reset();
    t_wrap();
    t_post();
    t_hold();
    complete_run();
  end
  // the whole sequence needs under a thousand cycles; 40000 leaves wide margin
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
endmodule : tb_period_match_timer8
`default_nettype wire
